// ===== rtl/hpc_bank.sv
// product-identifier selection and device-configuration controls of the hub
// assumes a byte register port fed by the eeprom loader or smbus slave
// Notes on behaviour
// - superspeed reports the low id byte as is, usb 2.0 reports it xor 02h.
// - loaded id bytes are used when the loaded product and vendor ids are non-zero.
// - with zero loaded ids, a non-zero otp id is used.
// - with zero otp too, the built-in default id is used.
// - bit 7 opens the manufacturer/product strings, lengths and language id to writes.
// - bit 6 opens the serial string and its length to writes.
// - bit 5 blocks u1/u2 on every port unless a forced accept was seen.
// - after a forced accept, u1/u2 follow protocol until por or upstream disconnect.
// - bit 4 reads one, bit 0 reads zero, neither writable.
// - with bit 2 clear, bit 3 gangs all port switches onto the first control pin.
// - bit 2 set turns port power status reporting off.
// - with bit 1 set, a non-zero downstream timeout becomes ffh, zero stays zero.
// - in i2c mode the control bits load from eeprom.
// - in smbus mode the host may overwrite the control bits.
// - an eeprom whose first byte is not 55h is abandoned and defaults stay.
`timescale 1ns/1ps
`default_nettype none
module hpc_bank (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic smbus_mode, // 1 smbus slave, 0 i2c eeprom master
  input wire logic load_start, // pulse: eeprom load begins
  input wire logic load_valid, // byte strobe from eeprom or smbus
  input wire logic [7:0] load_addr, // register offset of byte
  input wire logic [7:0] load_data, // byte value
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rd_addr, // read offset
  output logic [7:0] rd_data, // read byte, registered
  input wire logic [15:0] vendor_ident_loaded, // vendor id as loaded elsewhere
  input wire logic [7:0] otp_ident_low, // otp product id low
  input wire logic [7:0] otp_ident_high, // otp product id high
  output logic [7:0] product_ident_low, // superspeed low id
  output logic [7:0] product_ident_high, // high id
  output logic [7:0] product_ident_low_usb2, // usb 2.0 low id
  output logic string_write_enable, // string regs writable
  output logic serial_string_write_enable, // serial regs writable
  input wire logic forced_link_pm_accept, // pulse: forced accept sent or received
  input wire logic upstream_disconnect, // pulse: upstream port disconnected
  output logic link_low_power_allow, // u1/u2 may be initiated or accepted
  input wire logic [hpc_pkg::NUM_PORTS-1:0] port_power_request, // per-port switch request
  output logic [hpc_pkg::NUM_PORTS-1:0] port_power_control_pin, // switch enables
  output logic power_status_report_on, // switching status reported
  input wire logic [7:0] host_timeout, // host-programmed u1/u2 timeout
  output logic [7:0] effective_timeout // timeout applied downstream
);
  localparam logic [7:0] DEF_PID_LOW = 8'h00; // arbitrary neutral default id
  localparam logic [7:0] DEF_PID_HIGH = 8'h00; // arbitrary neutral default id

  hpc_wr_if wr ();
  logic eeprom_ok_ff;
  logic first_byte_ff;
  logic forced_seen_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] sel_low;
  logic [7:0] sel_high;
  logic [7:0] cfg;
  hpc_pkg::hpc_src_type src;

  hpc_cfg_store u_store (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .wr(wr)
  );
  assign cfg = wr.cfg;

  // first eeprom byte is the validity marker
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eeprom_ok_ff <= 1'b0;
      first_byte_ff <= 1'b0;
    end else if (ce) begin
      if (load_start) begin
        first_byte_ff <= 1'b1;
        eeprom_ok_ff <= 1'b0;
      end else if (load_valid && first_byte_ff && !smbus_mode) begin
        first_byte_ff <= 1'b0;
        eeprom_ok_ff <= (load_data == hpc_pkg::EEPROM_VALID_MARKER);
      end
    end
  end

  // only the three bank registers are stored here; others are ignored
  assign wr.wr_en = load_valid && !first_byte_ff
    && (smbus_mode || eeprom_ok_ff)
    && (load_addr == hpc_pkg::REG_PID_LOW_OFS || load_addr == hpc_pkg::REG_PID_HIGH_OFS
      || load_addr == hpc_pkg::REG_DEV_CFG_OFS);
  assign wr.wr_addr = load_addr;
  assign wr.wr_data = load_data;

  // identifier source priority
  always_comb begin
    if (wr.pid_written && ({wr.pid_high, wr.pid_low} != 16'h0000)
        && (vendor_ident_loaded != 16'h0000)) begin
      src = hpc_pkg::SRC_LOADED;
    end else if ({otp_ident_high, otp_ident_low} != 16'h0000) begin
      src = hpc_pkg::SRC_OTP;
    end else begin
      src = hpc_pkg::SRC_DEFAULT;
    end
  end

  always_comb begin
    case (src)
      hpc_pkg::SRC_LOADED: begin
        sel_low = wr.pid_low;
        sel_high = wr.pid_high;
      end
      hpc_pkg::SRC_OTP: begin
        sel_low = otp_ident_low;
        sel_high = otp_ident_high;
      end
      default: begin
        sel_low = DEF_PID_LOW;
        sel_high = DEF_PID_HIGH;
      end
    endcase
  end

  assign product_ident_low = sel_low;
  assign product_ident_high = sel_high;
  assign product_ident_low_usb2 = sel_low ^ hpc_pkg::USB2_PID_XOR;

  assign string_write_enable = cfg[hpc_pkg::CFG_STRINGS_BIT];
  assign serial_string_write_enable = cfg[hpc_pkg::CFG_SERIAL_BIT];

  // forced accept latches until reset or upstream disconnect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      forced_seen_ff <= 1'b0;
    end else if (ce) begin
      if (forced_link_pm_accept) begin
        forced_seen_ff <= 1'b1;
      end else if (upstream_disconnect) begin
        forced_seen_ff <= 1'b0;
      end
    end
  end

  assign link_low_power_allow = !cfg[hpc_pkg::CFG_LPM_OFF_BIT] || forced_seen_ff;

  // ganging only meaningful with status reporting on
  genvar gi;
  generate
    for (gi = 0; gi < hpc_pkg::NUM_PORTS; gi++) begin : g_port
      assign port_power_control_pin[gi] =
        (!cfg[hpc_pkg::CFG_PWR_REPORT_OFF_BIT] && cfg[hpc_pkg::CFG_GANGED_BIT])
        ? port_power_request[0] : port_power_request[gi];
    end
  endgenerate

  assign power_status_report_on = !cfg[hpc_pkg::CFG_PWR_REPORT_OFF_BIT];

  assign effective_timeout = (cfg[hpc_pkg::CFG_TIMEOUT_OVR_BIT] && host_timeout != 8'h00)
    ? hpc_pkg::TIMEOUT_MAX : host_timeout;

  // readback shows the identifiers in use, not the raw written bytes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data_ff <= 8'h00;
    end else if (ce && rd_en) begin
      case (rd_addr)
        hpc_pkg::REG_PID_LOW_OFS: rd_data_ff <= sel_low;
        hpc_pkg::REG_PID_HIGH_OFS: rd_data_ff <= sel_high;
        hpc_pkg::REG_DEV_CFG_OFS: rd_data_ff <= cfg;
        default: rd_data_ff <= 8'h00;
      endcase
    end
  end
  assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

// ===== rtl/hpc_cfg_store.sv
// storage for identifier bytes and the configuration byte
// assumes writes arrive already qualified by mode and eeprom validity
`timescale 1ns/1ps
`default_nettype none
module hpc_cfg_store (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic ce, // clock enable
  hpc_wr_if.store wr // write channel
);
  logic [7:0] cfg_ff;
  logic [7:0] pid_low_ff;
  logic [7:0] pid_high_ff;
  logic pid_written_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_ff <= hpc_pkg::DEV_CFG_RESET;
    end else if (ce && wr.wr_en && wr.wr_addr == hpc_pkg::REG_DEV_CFG_OFS) begin
      // reserved bits keep their fixed values
      cfg_ff <= (wr.wr_data & hpc_pkg::DEV_CFG_WMASK) | hpc_pkg::DEV_CFG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pid_low_ff <= 8'h00;
      pid_high_ff <= 8'h00;
      pid_written_ff <= 1'b0;
    end else if (ce && wr.wr_en) begin
      if (wr.wr_addr == hpc_pkg::REG_PID_LOW_OFS) begin
        pid_low_ff <= wr.wr_data;
        pid_written_ff <= 1'b1;
      end
      if (wr.wr_addr == hpc_pkg::REG_PID_HIGH_OFS) begin
        pid_high_ff <= wr.wr_data;
        pid_written_ff <= 1'b1;
      end
    end
  end

  assign wr.cfg = cfg_ff;
  assign wr.pid_low = pid_low_ff;
  assign wr.pid_high = pid_high_ff;
  assign wr.pid_written = pid_written_ff;
endmodule
`default_nettype wire

// ===== rtl/hpc_pkg.sv
// constants for the hub product-identifier and device-configuration bank
// assumes a single 200 MHz clock domain and a byte-wide register port
`default_nettype none
package hpc_pkg;
  localparam logic [7:0] REG_PID_LOW_OFS = 8'h03;
  localparam logic [7:0] REG_PID_HIGH_OFS = 8'h04;
  localparam logic [7:0] REG_DEV_CFG_OFS = 8'h05;
  localparam logic [7:0] DEV_CFG_RESET = 8'h10;
  localparam int CFG_STRINGS_BIT = 7;
  localparam int CFG_SERIAL_BIT = 6;
  localparam int CFG_LPM_OFF_BIT = 5;
  localparam int CFG_RSVD_ONE_BIT = 4;
  localparam int CFG_GANGED_BIT = 3;
  localparam int CFG_PWR_REPORT_OFF_BIT = 2;
  localparam int CFG_TIMEOUT_OVR_BIT = 1;
  localparam int CFG_RSVD_ZERO_BIT = 0;
  // writable configuration bits: 7,6,5,3,2,1
  localparam logic [7:0] DEV_CFG_WMASK = 8'hee;
  localparam logic [7:0] USB2_PID_XOR = 8'h02;
  localparam logic [7:0] EEPROM_VALID_MARKER = 8'h55;
  localparam logic [7:0] TIMEOUT_MAX = 8'hff;
  localparam int NUM_PORTS = 4;
  typedef enum logic [1:0] {
    SRC_DEFAULT = 2'b00,
    SRC_OTP = 2'b01,
    SRC_LOADED = 2'b10
  } hpc_src_type;
endpackage
`default_nettype wire

// ===== rtl/hpc_wr_if.sv
// write channel between the bank top and its configuration store
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface hpc_wr_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] cfg;
  logic [7:0] pid_low;
  logic [7:0] pid_high;
  logic pid_written;
  modport top (output wr_en, output wr_addr, output wr_data,
    input cfg, input pid_low, input pid_high, input pid_written);
  modport store (input wr_en, input wr_addr, input wr_data,
    output cfg, output pid_low, output pid_high, output pid_written);
endinterface
`default_nettype wire

// ===== testbench/hpc_asserts.sv
// port assertions for the id and configuration bank
// assumes binding onto hpc_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hpc_asserts (
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic ce, // enable
  input wire logic rd_en, // read
  input wire logic [7:0] rd_addr, // offset
  input wire logic [7:0] rd_data, // data
  input wire logic [15:0] vendor_ident_loaded, // vid
  input wire logic [7:0] otp_ident_low, // otp
  input wire logic [7:0] otp_ident_high, // otp
  input wire logic [7:0] product_ident_low, // id
  input wire logic [7:0] product_ident_high, // id
  input wire logic [7:0] product_ident_low_usb2, // id
  input wire logic string_write_enable, // bit 7
  input wire logic serial_string_write_enable, // bit 6
  input wire logic forced_link_pm_accept, // accept
  input wire logic link_low_power_allow, // u1/u2
  input wire logic [hpc_pkg::NUM_PORTS-1:0] port_power_request, // req
  input wire logic [hpc_pkg::NUM_PORTS-1:0] port_power_control_pin, // pins
  input wire logic power_status_report_on, // report
  input wire logic [7:0] host_timeout, // timeout
  input wire logic [7:0] effective_timeout // applied
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_usb2_xor: assert property (product_ident_low_usb2 == (product_ident_low ^ 8'h02))
    else $error("usb2 id wrong");
  a_otp_id_used: assert property (vendor_ident_loaded == 16'h0 && otp_ident_high != 8'h0
    |-> product_ident_high == otp_ident_high && product_ident_low == otp_ident_low)
    else $error("otp id not used");
  a_timeout_zero: assert property (host_timeout == 8'h0 |-> effective_timeout == 8'h0)
    else $error("zero timeout changed");
  a_timeout_max: assert property (host_timeout != 8'h0
    |-> effective_timeout == 8'hff || effective_timeout == host_timeout)
    else $error("timeout wrong");
  a_cfg_read: assert property ((ce && rd_en && rd_addr == 8'h05) |=> rd_data[4]
    && !rd_data[0] && rd_data[7] == $past(string_write_enable)
    && rd_data[2] != $past(power_status_report_on)
    && rd_data[6] == $past(serial_string_write_enable))
    else $error("cfg readback wrong");
  a_unmapped_read: assert property ((ce && rd_en && rd_addr > 8'h05)
    |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_forced_allow: assert property ((ce && forced_link_pm_accept)
    |=> link_low_power_allow)
    else $error("u1/u2 not allowed");
  a_pin_map: assert property (power_status_report_on |-> port_power_control_pin ==
    port_power_request || port_power_control_pin == {hpc_pkg::NUM_PORTS{port_power_request[0]}})
    else $error("power pins wrong");
endmodule
bind hpc_bank hpc_asserts u_hpc_asserts (.clk, .nrst, .ce, .rd_en, .rd_addr, .rd_data,
  .vendor_ident_loaded, .otp_ident_low, .otp_ident_high, .product_ident_low,
  .product_ident_high, .product_ident_low_usb2, .string_write_enable,
  .serial_string_write_enable, .forced_link_pm_accept, .link_low_power_allow,
  .port_power_request, .port_power_control_pin, .power_status_report_on,
  .host_timeout, .effective_timeout);
`default_nettype wire

// ===== testbench/hpc_loader.sv
// eeprom loader and smbus host model on the byte load port
// assumes the bank samples on rising clk; drives 1 ns after it
`timescale 1ns/1ps
`default_nettype none
module hpc_loader (
  input wire logic clk, // clock
  output logic load_start, // load begin
  output logic load_valid, // byte strobe
  output logic [7:0] load_addr, // offset
  output logic [7:0] load_data // byte
);
  initial begin
    load_start = 1'b0;
    load_valid = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    load_valid = 1'b1;
    load_addr = a;
    load_data = d;
  endtask
  task automatic start(input logic [7:0] marker);
    @(posedge clk) #1 load_start = 1'b1;
    @(posedge clk) #1 load_start = 1'b0;
    wr(8'h00, marker);
  endtask
  // released lines flip so stale bytes never look valid
  task automatic idle();
    @(posedge clk) #1;
    load_valid = 1'b0;
    load_addr = ~load_addr;
    load_data = ~load_data;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// bench for the id and configuration bank: table rows, then id, reset and load cases
// assumes hpc_loader feeds the load port and hpc_asserts is bound to the bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] w, tmo, cfg, eff;} hpc_row_type;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, smbus_mode = 1'b1, rd_en = 1'b0;
  logic forced_link_pm_accept = 1'b0, upstream_disconnect = 1'b0, load_start, load_valid;
  logic string_write_enable, serial_string_write_enable, link_low_power_allow;
  logic power_status_report_on;
  logic [7:0] rd_addr = 8'h00, host_timeout = 8'h00, otp_ident_low = 8'h00;
  logic [7:0] otp_ident_high = 8'h00, load_addr, load_data, rd_data, effective_timeout;
  logic [7:0] product_ident_low, product_ident_high, product_ident_low_usb2;
  logic [15:0] vendor_ident_loaded = 16'h0000;
  logic [3:0] port_power_request = 4'b1010, port_power_control_pin;
  int n_errors = 0, checks_done = 0;
  hpc_row_type r;
  hpc_row_type rows [8] = '{'{8'h02, 8'h01, 8'h12, 8'hff}, '{8'h02, 8'h00, 8'h12, 8'h00},
    '{8'h02, 8'hfe, 8'h12, 8'hff}, '{8'h00, 8'h37, 8'h10, 8'h37}, '{8'hff, 8'h80, 8'hfe, 8'hff},
    '{8'h24, 8'h05, 8'h34, 8'h05}, '{8'h08, 8'h01, 8'h18, 8'h01}, '{8'h41, 8'h00, 8'h50, 8'h00}};
  always #2.5 clk = ~clk;
  hpc_bank u_hpc_bank (.clk, .nrst, .ce, .smbus_mode, .load_start, .load_valid, .load_addr,
    .load_data, .rd_en, .rd_addr, .rd_data, .vendor_ident_loaded, .otp_ident_low,
    .otp_ident_high, .product_ident_low, .product_ident_high, .product_ident_low_usb2,
    .string_write_enable, .serial_string_write_enable, .forced_link_pm_accept,
    .upstream_disconnect, .link_low_power_allow, .port_power_request,
    .port_power_control_pin, .power_status_report_on, .host_timeout, .effective_timeout);
  hpc_loader u_hpc_loader (.clk, .load_start, .load_valid, .load_addr, .load_data);
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk) #1;
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    u_hpc_loader.wr(a, d);
    u_hpc_loader.idle();
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      host_timeout = r.tmo;
      put(8'h05, r.w);
      rd(8'h05);
      chk8(rd_data, r.cfg);
      chk8(effective_timeout, r.eff);
      chk8({string_write_enable, serial_string_write_enable, link_low_power_allow,
        power_status_report_on, 4'h0}, {r.cfg[7:6], ~r.cfg[5], ~r.cfg[2], 4'h0});
      if (!r.cfg[2]) chk8({4'h0, port_power_control_pin}, r.cfg[3] ? 8'h00 : 8'h0a);
    end
    $display("table rows done");
    chk8(product_ident_high | product_ident_low, 8'h00);
    {otp_ident_high, otp_ident_low} = 16'h1234;
    #1 chk8(product_ident_low_usb2, 8'h36);
    put(8'h03, 8'hab);
    put(8'h04, 8'hcd);
    vendor_ident_loaded = 16'h1111;
    rd(8'h03);
    chk8(rd_data, 8'hab);
    chk8(product_ident_low, 8'hab);
    chk8(product_ident_high, 8'hcd);
    chk8(product_ident_low_usb2, 8'ha9);
    rd(8'h07);
    chk8(rd_data, 8'h00);
    $display("ident test done");
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    rd(8'h05);
    chk8(rd_data, 8'h10);
    chk8(product_ident_low, 8'h34);
    $display("reset test done");
    smbus_mode = 1'b0;
    put(8'h05, 8'h20);
    u_hpc_loader.start(8'h54);
    put(8'h05, 8'h20);
    rd(8'h05);
    chk8(rd_data, 8'h10);
    u_hpc_loader.start(8'h55);
    put(8'h05, 8'h2c);
    rd(8'h05);
    chk8(rd_data, 8'h3c);
    chk8({7'h0, link_low_power_allow}, 8'h00);
    forced_link_pm_accept = 1'b1;
    @(posedge clk) #1 forced_link_pm_accept = 1'b0;
    chk8({7'h0, link_low_power_allow}, 8'h01);
    upstream_disconnect = 1'b1;
    @(posedge clk) #1 upstream_disconnect = 1'b0;
    chk8({7'h0, link_low_power_allow}, 8'h00);
    $display("eeprom test done");
    stop_test();
  end
  // whole run is under a hundred cycles
  initial begin
    #20000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
